// ===== ssi_params.svh
// Summary of operation
// RQ1: Capture serial data on rising clock edge.
// RQ2: Ignore serial data while select is high.
// RQ3: Update serial output on falling clock edge.
// RQ4: Serial output floats while select is high.
// RQ5: Internal mode: strobe low during conversion.
// RQ6: External mode: strobe high two periods before MSB.
// RQ7: Strobe floats on high select, external only.
// RQ8: Host keeps clocking, duty 45 to 55 percent.
// RQ9: Decode three-level shutdown into two controls.
// RQ10: Track after sixth bit, hold after eighth.
// RQ11: Host sends control byte before each conversion.
// RQ12: Control bits two, three select input mode.
// RQ13: Result shifts out MSB first, falling edges.
// RQ14: Select high clears the serial bit counter.
`ifndef SSI_PARAMS_SVH
`define SSI_PARAMS_SVH

`define SSI_CTRL_BITS 4'h8
`define SSI_TRACK_AFTER 4'h6
`define SSI_RESULT_BITS 4'h8
`define SSI_SGL_POS 2
`define SSI_UNI_POS 3
`define SSI_SEL_LSB 4
`define SSI_PD_LSB 0
`define SSI_EXT_CLK_CODE 2'h3
`define SSI_EXT_STRB_RISE 4'h1
`define SSI_STRB_PERIODS 4'h2
`define SSI_CLK_PERIOD_NS 25
`define SSI_INT_CONV_NS 7500
`define SSI_STRB_RESET 1'b1

`endif

// ===== ssi_pkg.sv
package ssi_pkg;

  typedef enum logic [1:0] {
    SSI_ST_IDLE = 2'b00,
    SSI_ST_EXT_CONV = 2'b01,
    SSI_ST_INT_CONV = 2'b10,
    SSI_ST_SHIFT = 2'b11
  } ssi_state_e;

  typedef logic [15:0] ssi_timer_t;

  typedef struct packed {
    ssi_state_e st;
    logic sclk_q;
    logic [3:0] bit_cnt;
    logic [7:0] ctrl;
    logic [7:0] cfg;
    logic [3:0] fall_cnt;
    ssi_timer_t timer;
    logic [7:0] shift;
    logic [3:0] out_cnt;
    logic dout;
    logic strobe;
    logic ext_mode;
    logic track;
    logic hold;
    logic conv_start;
  } ssi_core_s;

endpackage

// ===== ssi_pin_sync.sv
`timescale 1ns/1ps

module ssi_pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ssi_sync_s;

  ssi_sync_s s;
  ssi_sync_s next_s;

  always_comb begin
    next_s.meta = async_i;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_o = s.stable;

endmodule // ssi_pin_sync

// ===== ssi_serial_strobe.sv
`timescale 1ns/1ps
`include "ssi_params.svh"

module ssi_serial_strobe #(
  parameter int INT_CONV_TIME_NS = `SSI_INT_CONV_NS
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic tri_level_power_down_low_i,
  input wire logic tri_level_power_down_high_i,
  input wire logic [7:0] result_i,
  output logic dout_o,
  output logic dout_oe_o,
  output logic conversion_strobe_o,
  output logic conversion_strobe_oe_o,
  output logic track_o,
  output logic hold_o,
  output logic conv_start_o,
  output logic ext_clock_mode_o,
  output logic single_ended_o,
  output logic unipolar_o,
  output logic [2:0] channel_sel_o,
  output logic power_down_o,
  output logic reference_disable_o
);
  import ssi_pkg::*;

  // Rounded up, so a short conversion time never ends before it has elapsed.
  localparam int INT_CONV_CYC_INT =
    (INT_CONV_TIME_NS + `SSI_CLK_PERIOD_NS - 1) / `SSI_CLK_PERIOD_NS;
  localparam ssi_timer_t INT_CONV_CYC =
    ssi_timer_t'((INT_CONV_CYC_INT < 1) ? 1 : INT_CONV_CYC_INT);

  logic [2:0] link_sync;
  logic [1:0] pd_sync;
  logic sclk_s;
  logic din_s;
  logic pd_low_s;
  logic pd_high_s;
  logic cs_act;
  logic sclk_rise;
  logic sclk_fall;
  logic ctrl_rise;
  logic track_fall;
  logic byte_fall;
  logic ext_code;
  logic [3:0] fall_cnt_inc;
  logic strb_rise_hit;
  logic msb_hit;
  logic int_done;

  ssi_core_s s;
  ssi_core_s next_s;

  // Select is inverted before synchronising, so the cleared flops read as deselected after
  // reset and no phantom transfer opens before the first real select.
  // Data and clock share one latency, so the setup time seen at the pins is preserved.
  ssi_pin_sync #(
    .WIDTH(3)
  ) u_link_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({~cs_n_i, sclk_i, din_i}),
    .sync_o(link_sync)
  );

  // The shutdown levels change rarely and are synchronised on their own.
  ssi_pin_sync #(
    .WIDTH(2)
  ) u_pd_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({tri_level_power_down_low_i, tri_level_power_down_high_i}),
    .sync_o(pd_sync)
  );

  assign cs_act = link_sync[2];
  assign sclk_s = link_sync[1];
  assign din_s = link_sync[0];
  assign pd_low_s = pd_sync[1];
  assign pd_high_s = pd_sync[0];

  assign sclk_rise = cs_act && sclk_s && !s.sclk_q; // RQ2
  assign sclk_fall = cs_act && !sclk_s && s.sclk_q;

  // Control byte progress is judged on the count before this edge.
  assign ctrl_rise = sclk_rise && (s.bit_cnt < `SSI_CTRL_BITS);
  assign track_fall = sclk_fall && (s.bit_cnt == `SSI_TRACK_AFTER);
  assign byte_fall = sclk_fall && (s.bit_cnt == `SSI_CTRL_BITS);
  assign ext_code = (s.ctrl[`SSI_PD_LSB +: 2] == `SSI_EXT_CLK_CODE);

  // The strobe rises on the first fall after hold and drops two falls later, with the MSB.
  assign fall_cnt_inc = s.fall_cnt + 4'h1;
  assign strb_rise_hit = (fall_cnt_inc == `SSI_EXT_STRB_RISE);
  assign msb_hit = (fall_cnt_inc == (`SSI_EXT_STRB_RISE + `SSI_STRB_PERIODS));
  assign int_done = (s.timer == ssi_timer_t'(1));

  always_comb begin
    next_s = s;
    next_s.sclk_q = sclk_s;
    next_s.conv_start = 1'b0;
    case (s.st)
      SSI_ST_IDLE: begin
        if (ctrl_rise) begin
          next_s.ctrl = {s.ctrl[6:0], din_s}; // RQ1
          next_s.bit_cnt = s.bit_cnt + 4'h1;
        end
        if (track_fall) begin
          next_s.track = 1'b1; // RQ10
        end
        if (byte_fall) begin
          // The conversion only starts from a full control byte.
          next_s.track = 1'b0; // RQ10
          next_s.hold = 1'b1;
          next_s.conv_start = 1'b1; // RQ11
          next_s.cfg = s.ctrl; // RQ12
          next_s.dout = 1'b0;
          if (ext_code) begin
            next_s.ext_mode = 1'b1;
            next_s.strobe = 1'b0;
            next_s.fall_cnt = 4'h0;
            next_s.st = SSI_ST_EXT_CONV;
          end else begin
            next_s.ext_mode = 1'b0;
            next_s.strobe = 1'b0; // RQ5
            next_s.timer = INT_CONV_CYC;
            next_s.st = SSI_ST_INT_CONV;
          end
        end
      end
      SSI_ST_EXT_CONV: begin
        // The host clock paces this conversion, so it must keep running.
        if (sclk_fall) begin // RQ8
          next_s.fall_cnt = fall_cnt_inc;
          if (strb_rise_hit) begin
            next_s.strobe = 1'b1; // RQ6
          end
          // The host sees the strobe drop and the MSB appear on the same falling edge.
          if (msb_hit) begin
            next_s.strobe = 1'b0; // RQ6
            next_s.dout = result_i[7]; // RQ13
            next_s.shift = {result_i[6:0], 1'b0};
            next_s.out_cnt = `SSI_RESULT_BITS - 4'h1;
            next_s.hold = 1'b0;
            next_s.st = SSI_ST_SHIFT;
          end
        end
      end
      SSI_ST_INT_CONV: begin
        // The whole result is latched at once, so the core may move on during readout.
        if (int_done) begin
          next_s.strobe = 1'b1; // RQ5
          next_s.shift = result_i;
          next_s.out_cnt = `SSI_RESULT_BITS;
          next_s.hold = 1'b0;
          next_s.st = SSI_ST_SHIFT;
        end else begin
          next_s.timer = s.timer - ssi_timer_t'(1);
        end
      end
      SSI_ST_SHIFT: begin
        if (sclk_fall) begin
          if (s.out_cnt != 4'h0) begin
            next_s.dout = s.shift[7]; // RQ3 RQ13
            next_s.shift = {s.shift[6:0], 1'b0};
            next_s.out_cnt = s.out_cnt - 4'h1;
          end else begin
            // One more falling edge after the last bit returns the port to idle.
            next_s.dout = 1'b0;
            next_s.bit_cnt = 4'h0;
            next_s.st = SSI_ST_IDLE;
          end
        end
      end
      default: begin
        next_s.st = SSI_ST_IDLE;
      end
    endcase
    if (!cs_act) begin
      // An internal conversion runs on its own timer and survives a deselect.
      next_s.bit_cnt = 4'h0; // RQ14
      next_s.track = 1'b0;
      if (s.st != SSI_ST_INT_CONV) begin
        next_s.st = SSI_ST_IDLE;
        next_s.hold = 1'b0;
        next_s.dout = 1'b0;
        if (s.ext_mode) begin
          next_s.strobe = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.st <= SSI_ST_IDLE;
      // A high strobe after reset reads as an internal conversion already finished.
      s.strobe <= `SSI_STRB_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign dout_o = s.dout;
  // The dout enable and the external-mode strobe enable follow the synchronised select directly, so no flop delays the release.
  assign dout_oe_o = cs_act; // RQ4
  assign conversion_strobe_o = s.strobe;
  assign conversion_strobe_oe_o = !s.ext_mode || cs_act; // RQ7
  assign track_o = s.track;
  assign hold_o = s.hold;
  assign conv_start_o = s.conv_start;
  assign ext_clock_mode_o = s.ext_mode;
  assign single_ended_o = s.cfg[`SSI_SGL_POS]; // RQ12
  assign unipolar_o = s.cfg[`SSI_UNI_POS]; // RQ12
  assign channel_sel_o = s.cfg[`SSI_SEL_LSB +: 3];
  // Low means full power-down; high disables only the reference; open means run.
  assign power_down_o = pd_low_s; // RQ9
  assign reference_disable_o = pd_high_s && !pd_low_s; // RQ9

endmodule // ssi_serial_strobe

// ===== ssi_serial_strobe_checker.sv
`timescale 1ns/1ps

module ssi_serial_strobe_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic tri_level_power_down_low_i,
  input wire logic tri_level_power_down_high_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire logic conversion_strobe_o,
  input wire logic conversion_strobe_oe_o,
  input wire logic track_o,
  input wire logic hold_o,
  input wire logic conv_start_o,
  input wire logic ext_clock_mode_o,
  input wire logic power_down_o,
  input wire logic reference_disable_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Pins must persist three samples to clear the two-flop synchronisers.
  sequence cs_hi; cs_n_i [*3]; endsequence
  sequence ext_pulse; conversion_strobe_o [*8] ##1 conversion_strobe_o [*8] ##1 !conversion_strobe_o; endsequence
  wire ref_pin = tri_level_power_down_high_i && !tri_level_power_down_low_i;
  a_dout_float: assert property (cs_hi |-> !dout_oe_o) else $error("dout driven");
  a_strb_held: assert property (!ext_clock_mode_o |-> conversion_strobe_oe_o) else $error("oe");
  a_strb_float: assert property (cs_hi ##0 ext_clock_mode_o |-> !conversion_strobe_oe_o)
    else $error("strobe driven");
  a_ext_pulse: assert property ($rose(conversion_strobe_o) && ext_clock_mode_o |-> ext_pulse)
    else $error("pulse width");
  a_int_done: assert property ($rose(conversion_strobe_o) && !ext_clock_mode_o |-> !hold_o)
    else $error("hold stuck");
  a_int_busy: assert property (hold_o && !ext_clock_mode_o |-> !conversion_strobe_o)
    else $error("strobe high");
  a_track_hold: assert property ($rose(hold_o) |-> $past(track_o) && !track_o)
    else $error("track order");
  a_start_pulse: assert property (conv_start_o |-> $rose(hold_o) ##1 !conv_start_o)
    else $error("start pulse");
  a_dout_fall: assert property ($changed(dout_o) |-> !$past(sclk_i, 2) || $past(cs_n_i, 2))
    else $error("dout moved");
  a_pd_low: assert property (tri_level_power_down_low_i [*3] |-> power_down_o) else $error("pd");
  a_ref_off: assert property (ref_pin [*3] |-> reference_disable_o && !power_down_o)
    else $error("ref");
endmodule // ssi_serial_strobe_checker

bind ssi_serial_strobe ssi_serial_strobe_checker ssi_serial_strobe_checker_i (.*);

// ===== ssi_host_model.sv
`timescale 1ns/1ps

module ssi_host_model (
  input wire logic clk_i,
  input wire logic dout_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Four clocks low and four high keep the duty at 50 percent through conversion.
  task automatic cyc(input logic d, output logic s);
    din_o = d;
    tick(4);
    s = dout_i;
    sclk_o = 1'b1;
    tick(4);
    sclk_o = 1'b0;
  endtask
  task automatic send(input logic [7:0] c, input int n);
    logic s;
    cs_n_o = 1'b0;
    tick(4);
    for (int i = 7; i > 7 - n; i--) cyc(c[i], s);
  endtask
  task automatic read(input int nd, output logic [7:0] r);
    logic s;
    repeat (nd) cyc(1'b0, s);
    for (int i = 7; i >= 0; i--) cyc(1'b0, r[i]);
  endtask
  // A released data line shows the inverse so a stale bit is never mistaken for data.
  task automatic close();
    cs_n_o = 1'b1;
    din_o = ~din_o;
    tick(8);
  endtask
endmodule // ssi_host_model

// ===== tb.sv
`timescale 1ns/1ps

module tb;
  logic clk_i, rst_n_i, cs_n_i, sclk_i, din_i, dout_o, dout_oe_o, track_o, hold_o, conv_start_o;
  logic tri_level_power_down_low_i, tri_level_power_down_high_i, power_down_o, reference_disable_o;
  logic conversion_strobe_o, conversion_strobe_oe_o, ext_clock_mode_o, single_ended_o, unipolar_o;
  logic [7:0] result_i;
  logic [2:0] channel_sel_o;
  int miscompares, checked;
  ssi_serial_strobe #(.INT_CONV_TIME_NS(2500)) ssi_serial_strobe_i (.*);
  // A line that is not driven reads as the inverse of the current dout_o value.
  ssi_host_model ssi_host_model_i (.clk_i, .dout_i(dout_oe_o ? dout_o : ~dout_o),
    .cs_n_o(cs_n_i), .sclk_o(sclk_i), .din_o(din_i));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic t_pd();
    for (int i = 0; i < 3; i++) begin
      {tri_level_power_down_high_i, tri_level_power_down_low_i} = i[1:0];
      ssi_host_model_i.tick(4);
      chk("shutdown", {6'h0, i[1:0]}, {6'h0, reference_disable_o, power_down_o});
    end
    tri_level_power_down_high_i = 1'b0;
    $display("shutdown test done");
  endtask
  task automatic t_ext();
    logic [7:0] r;
    result_i = 8'hA5;
    ssi_host_model_i.send(8'hDF, 8);
    ssi_host_model_i.read(3, r);
    chk("ext result", 8'hA5, r);
    chk("ext config", 8'h2F, {2'h0, channel_sel_o, unipolar_o, single_ended_o, ext_clock_mode_o});
    ssi_host_model_i.close();
    chk("ext float", 8'h00, {6'h0, dout_oe_o, conversion_strobe_oe_o});
    $display("external clock test done");
  endtask
  task automatic t_int();
    logic [7:0] r;
    int n;
    result_i = 8'h3C;
    ssi_host_model_i.send(8'hFF, 3);
    ssi_host_model_i.close();
    ssi_host_model_i.send(8'h82, 8);
    ssi_host_model_i.tick(5);
    chk("busy strobe", 8'h00, {7'h0, conversion_strobe_o});
    for (n = 0; n < 400 && conversion_strobe_o !== 1'b1; n++) ssi_host_model_i.tick(1);
    if (n == 400) begin
      miscompares++;
      stop_test();
    end
    ssi_host_model_i.read(1, r);
    chk("int result", 8'h3C, r);
    chk("int config", 8'h00, {2'h0, channel_sel_o, unipolar_o, single_ended_o, ext_clock_mode_o});
    ssi_host_model_i.close();
    chk("int float", 8'h01, {6'h0, dout_oe_o, conversion_strobe_oe_o});
    $display("internal clock test done");
  endtask
  initial begin
    rst_n_i = 1'b0;
    result_i = 8'h00;
    tri_level_power_down_low_i = 1'b0;
    tri_level_power_down_high_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    chk("select after reset", 8'h00, {7'h0, dout_oe_o});
    ssi_host_model_i.tick(4);
    t_pd();
    t_ext();
    t_int();
    stop_test();
  end
endmodule // tb
